// [design/dbls_lane_steer.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: steer short and normal words between two memory buses and
//          the register files of the primary and secondary elements
// Assumes: memory presents the addressed row and the following row
// Notes:   results appear one clock after the request
//
// Contract
// - short words use two lanes, explicit lowest
// - paired short implied word on lane 47-32
// - other short lanes driven to zero
// - paired buses may differ in width
// - implied value goes to complement element
// - short load upper bits zero or sign
// - short load clears low eight bits
// - single normal on low lane, high zero
// - normal word chosen by address lsb
// - single-lane mode gives no implied value
// - paired normal: explicit low, implied high
// - implied normal word from next address
// - normal clears low bits, stores drop them
// - single-lane dual-data allows any width mix
// - single dual normal: upper lanes zero
// - paired dual implied on both upper lanes
// - dual-data with direct addressing is refused
// - two short address bits pick word
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module dbls_lane_steer (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // access mode
  input  wire logic               i_paired_lane_mode,
  input  wire logic               i_dual_data,
  input  wire logic               i_short_sign_extend_bit,
  // requests per bus
  input  dbls_pkg::dbls_req_t     i_prog_req,
  input  dbls_pkg::dbls_req_t     i_data_req,
  // memory rows read on each bus
  input  wire logic [63:0]        i_prog_row,
  input  wire logic [63:0]        i_prog_next_row,
  input  wire logic [63:0]        i_data_row,
  input  wire logic [63:0]        i_data_next_row,
  // bus images
  output logic      [63:0]        o_program_memory_bus,
  output logic      [63:0]        o_data_memory_bus,
  output logic                    o_prog_store,
  output logic                    o_data_store,
  // register file writes
  output dbls_pkg::dbls_wr_t      o_prog_expl_wr,
  output dbls_pkg::dbls_wr_t      o_prog_impl_wr,
  output dbls_pkg::dbls_wr_t      o_data_expl_wr,
  output dbls_pkg::dbls_wr_t      o_data_impl_wr,
  // refusal
  output logic                    o_reject
);
  import dbls_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // lane pickers

  function automatic logic [15:0] pick16(input logic [63:0] row, input logic [1:0] sel);
    logic [15:0] w;
    w = 16'h0000;
    case (sel)
      2'h0:    w = row[15:0];
      2'h1:    w = row[31:16];
      2'h2:    w = row[47:32];
      2'h3:    w = row[63:48];
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic logic [31:0] pick32(input logic [63:0] row, input logic sel);
    return sel ? row[63:32] : row[31:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // gather both buses into arrays

  dbls_req_t   req      [DBLS_NBUS];
  logic [63:0] row      [DBLS_NBUS];
  logic [63:0] next_row [DBLS_NBUS];
  logic        refuse;

  assign req[DBLS_BUS_PROG]      = i_prog_req;
  assign req[DBLS_BUS_DATA]      = i_data_req;
  assign row[DBLS_BUS_PROG]      = i_prog_row;
  assign row[DBLS_BUS_DATA]      = i_data_row;
  assign next_row[DBLS_BUS_PROG] = i_prog_next_row;
  assign next_row[DBLS_BUS_DATA] = i_data_next_row;

  // dual-data needs indirect addresses on both buses
  always_comb begin
    refuse = i_dual_data &&
             ((req[DBLS_BUS_PROG].valid && req[DBLS_BUS_PROG].direct) ||
              (req[DBLS_BUS_DATA].valid && req[DBLS_BUS_DATA].direct));
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-bus steering

  logic [63:0] bus_q   [DBLS_NBUS];
  logic        store_q [DBLS_NBUS];
  dbls_wr_t    expl_q  [DBLS_NBUS];
  dbls_wr_t    impl_q  [DBLS_NBUS];

  genvar b;
  generate
    for (b = 0; b < DBLS_NBUS; b++) begin : g_bus
      logic [31:0] mem_expl;
      logic [31:0] mem_impl;
      logic [39:0] ld_expl;
      logic [39:0] ld_impl;
      logic [31:0] st_expl;
      logic [31:0] st_impl;
      logic [31:0] lane_expl;
      logic [31:0] lane_impl;
      logic [63:0] next_bus;
      logic        take;
      logic        has_impl;

      // each bus keeps its own width, so mixed pairs fall out naturally
      assign take     = req[b].valid && !refuse;
      assign has_impl = i_paired_lane_mode;

      // word selection from the row
      always_comb begin
        mem_expl = 32'h0000_0000;
        mem_impl = 32'h0000_0000;
        if (req[b].width == DBLS_WIDTH_SHORT) begin
          mem_expl = {16'h0000, pick16(row[b], req[b].addr_lo)};
          // implied short word lies two words on, wrapping into the next row
          if (req[b].addr_lo[1]) begin
            mem_impl = {16'h0000, pick16(next_row[b], {1'b0, req[b].addr_lo[0]})};
          end else begin
            mem_impl = {16'h0000, pick16(row[b], {1'b1, req[b].addr_lo[0]})};
          end
        end else begin
          mem_expl = pick32(row[b], req[b].addr_lo[0]);
          if (req[b].addr_lo[0]) begin
            mem_impl = pick32(next_row[b], 1'b0);
          end else begin
            mem_impl = pick32(row[b], 1'b1);
          end
        end
      end

      dbls_word_fmt u_fmt_expl (
        .i_width                 (req[b].width),
        .i_short_sign_extend_bit (i_short_sign_extend_bit),
        .i_mem_word              (mem_expl),
        .o_reg_val               (ld_expl),
        .i_reg_val               (req[b].wdata_expl),
        .o_mem_word              (st_expl)
      );

      dbls_word_fmt u_fmt_impl (
        .i_width                 (req[b].width),
        .i_short_sign_extend_bit (i_short_sign_extend_bit),
        .i_mem_word              (mem_impl),
        .o_reg_val               (ld_impl),
        .i_reg_val               (req[b].wdata_impl),
        .o_mem_word              (st_impl)
      );

      // lane contents: memory words on loads, truncated registers on stores
      always_comb begin
        lane_expl = req[b].store ? st_expl : mem_expl;
        lane_impl = has_impl ? (req[b].store ? st_impl : mem_impl) : 32'h0000_0000;
      end

      // place words on lanes, zero everything else
      always_comb begin
        next_bus = DBLS_BUS_RST;
        if (take) begin
          if (req[b].width == DBLS_WIDTH_SHORT) begin
            next_bus[15:0] = lane_expl[15:0];
            next_bus[47:32] = lane_impl[15:0];
          end else begin
            next_bus[31:0] = lane_expl;
            next_bus[63:32] = lane_impl;
          end
        end
      end

      // bus image register
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          bus_q[b]   <= DBLS_BUS_RST;
          store_q[b] <= 1'b0;
        end else begin
          bus_q[b]   <= next_bus;
          store_q[b] <= take && req[b].store;
        end
      end

      // explicit register write
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          expl_q[b] <= DBLS_WR_RST;
        end else begin
          expl_q[b].valid   <= take && !req[b].store;
          expl_q[b].element <= req[b].element;
          expl_q[b].reg_idx <= req[b].reg_idx;
          expl_q[b].data    <= ld_expl;
        end
      end

      // implied register write to the complementary element
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          impl_q[b] <= DBLS_WR_RST;
        end else begin
          impl_q[b].valid   <= take && !req[b].store && has_impl;
          impl_q[b].element <= ~req[b].element;
          impl_q[b].reg_idx <= req[b].reg_idx;
          impl_q[b].data    <= ld_impl;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // refusal flag

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reject <= 1'b0;
    end else begin
      o_reject <= refuse;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_program_memory_bus = bus_q[DBLS_BUS_PROG];
  assign o_data_memory_bus    = bus_q[DBLS_BUS_DATA];
  assign o_prog_store         = store_q[DBLS_BUS_PROG];
  assign o_data_store         = store_q[DBLS_BUS_DATA];
  assign o_prog_expl_wr       = expl_q[DBLS_BUS_PROG];
  assign o_prog_impl_wr       = impl_q[DBLS_BUS_PROG];
  assign o_data_expl_wr       = expl_q[DBLS_BUS_DATA];
  assign o_data_impl_wr       = impl_q[DBLS_BUS_DATA];

endmodule

// [inc/dbls_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: shared widths, lane positions and carriers for lane steering
// Assumes: 64-bit program and data memory buses, 40-bit data registers
// Notes:   one access per clock, results registered once
////////////////////////////////////////////////////////////////////////////////
package dbls_pkg;

  // bus and register geometry
  localparam int unsigned DBLS_NBUS      = 2;
  localparam int unsigned DBLS_BUS_W     = 64;
  localparam int unsigned DBLS_REG_W     = 40;
  localparam int unsigned DBLS_SHORT_W   = 16;
  localparam int unsigned DBLS_NORM_W    = 32;
  localparam int unsigned DBLS_FILL_W    = 8;
  localparam int unsigned DBLS_IDX_W     = 4;

  // lane positions on a bus
  localparam int unsigned DBLS_SHORT_IMPL_LSB = 32;
  localparam int unsigned DBLS_NORM_HI_LSB    = 32;

  // bus numbering inside the block
  localparam int unsigned DBLS_BUS_PROG  = 0;
  localparam int unsigned DBLS_BUS_DATA  = 1;

  // access width codes
  localparam logic DBLS_WIDTH_SHORT  = 1'b0;
  localparam logic DBLS_WIDTH_NORMAL = 1'b1;

  // element codes
  localparam logic DBLS_PRIMARY_ELEMENT   = 1'b0;
  localparam logic DBLS_SECONDARY_ELEMENT = 1'b1;

  // values after reset
  localparam logic [63:0] DBLS_BUS_RST = 64'h0000_0000_0000_0000;

  // one access request on one bus
  typedef struct packed {
    logic        valid;
    logic        store;
    logic        width;
    logic [1:0]  addr_lo;
    logic        direct;
    logic        element;
    logic [3:0]  reg_idx;
    logic [39:0] wdata_expl;
    logic [39:0] wdata_impl;
  } dbls_req_t;

  // one register file write
  typedef struct packed {
    logic        valid;
    logic        element;
    logic [3:0]  reg_idx;
    logic [39:0] data;
  } dbls_wr_t;

  localparam dbls_wr_t DBLS_WR_RST = '{valid: 1'b0, element: 1'b0, reg_idx: 4'h0,
                                      data: 40'h00_0000_0000};

endpackage

// [design/dbls_word_fmt.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: format one memory word for a register and one register for memory
// Assumes: short words sit in register bits 23:8, normal words in 39:8
// Notes:   purely combinational; caller registers the results
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module dbls_word_fmt (
  // access shape
  input  wire logic        i_width,
  input  wire logic        i_short_sign_extend_bit,
  // load path
  input  wire logic [31:0] i_mem_word,
  output logic      [39:0] o_reg_val,
  // store path
  input  wire logic [39:0] i_reg_val,
  output logic      [31:0] o_mem_word
);
  import dbls_pkg::*;

  logic [15:0] ext16;

  always_comb begin
    // upper 16 bits follow the short-sign-extend bit
    ext16 = i_short_sign_extend_bit ? {16{i_mem_word[15]}} : 16'h0000;
    if (i_width == DBLS_WIDTH_SHORT) begin
      o_reg_val  = {ext16, i_mem_word[15:0], 8'h00};
      o_mem_word = {16'h0000, i_reg_val[23:8]};
    end else begin
      o_reg_val  = {i_mem_word, 8'h00};
      o_mem_word = i_reg_val[39:8];
    end
  end

endmodule

// [dv/dbls_mem_model.sv]
// Purpose: memory rows seen by the lane steering block
// Assumes: every row differs from its neighbour in every nibble
// Notes:   the row after the last one wraps to row zero
`timescale 1ns/1ps
module dbls_mem_model (
  // row select
  input  wire logic [3:0]  i_row,
  // addressed row and the one after it
  output logic      [63:0] o_row,
  output logic      [63:0] o_next_row
);
  import dbls_pkg::*;
  localparam logic [63:0] SEED = 64'hF1E2_D3C4_B5A6_9788;
  assign o_row      = SEED ^ {16{i_row}};
  assign o_next_row = SEED ^ {16{i_row + 4'h1}};
endmodule

// [dv/dbls_lane_steer_monitor.sv]
// Purpose: concurrent checks on the lane steering ports
// Assumes: one clock of latency, synchronous reset
// Notes:   data bus side watched in detail
`timescale 1ns/1ps
module dbls_lane_steer_monitor (
  // clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst,
  // access mode and requests
  input wire logic          i_paired_lane_mode,
  input wire logic          i_dual_data,
  input dbls_pkg::dbls_req_t i_prog_req,
  input dbls_pkg::dbls_req_t i_data_req,
  // results
  input wire logic [63:0]   o_data_memory_bus,
  input wire logic          o_data_store,
  input dbls_pkg::dbls_wr_t o_prog_impl_wr,
  input dbls_pkg::dbls_wr_t o_data_expl_wr,
  input dbls_pkg::dbls_wr_t o_data_impl_wr,
  input wire logic          o_reject
);
  import dbls_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic refuse;
  logic dgo;
  assign refuse = i_dual_data && ((i_prog_req.valid && i_prog_req.direct)
                  || (i_data_req.valid && i_data_req.direct));
  assign dgo = i_data_req.valid && !refuse;
  ////////////////////////////////////////////////////////////////////////////
  property p_reject;
    refuse |=> o_reject && o_data_memory_bus == 64'h0 && !o_data_expl_wr.valid;
  endproperty
  a_reject: assert property (p_reject) else $error("refused access not blocked");
  property p_latency;
    dgo && !i_data_req.store |=> o_data_expl_wr.valid && !o_data_store;
  endproperty
  a_latency: assert property (p_latency) else $error("load write late");
  property p_low_clear;
    o_data_expl_wr.valid |-> o_data_expl_wr.data[7:0] == 8'h00;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low byte not clear");
  property p_short_lanes;
    dgo && i_data_req.width == DBLS_WIDTH_SHORT
      |=> o_data_memory_bus[31:16] == 16'h0 && o_data_memory_bus[63:48] == 16'h0;
  endproperty
  a_short_lanes: assert property (p_short_lanes) else $error("idle lane driven");
  property p_single_impl;
    !i_paired_lane_mode |=> !o_prog_impl_wr.valid && !o_data_impl_wr.valid;
  endproperty
  a_single_impl: assert property (p_single_impl) else $error("implied write");
  property p_single_upper;
    dgo && !i_paired_lane_mode && i_data_req.width == DBLS_WIDTH_NORMAL
      |=> o_data_memory_bus[63:32] == 32'h0;
  endproperty
  a_single_upper: assert property (p_single_upper) else $error("upper lane driven");
  property p_compl;
    o_data_impl_wr.valid |-> o_data_impl_wr.element != o_data_expl_wr.element
      && o_data_impl_wr.reg_idx == o_data_expl_wr.reg_idx;
  endproperty
  a_compl: assert property (p_compl) else $error("implied target wrong");
  property p_store;
    dgo && i_data_req.store && i_data_req.width == DBLS_WIDTH_NORMAL
      |=> o_data_store && o_data_memory_bus[31:0] == $past(i_data_req.wdata_expl[39:8]);
  endproperty
  a_store: assert property (p_store) else $error("store word wrong");
  c_reject: cover property (o_reject);
  c_short: cover property (dgo && i_paired_lane_mode && !i_data_req.width);
  c_store: cover property (o_data_store);
endmodule
bind dbls_lane_steer dbls_lane_steer_monitor i_dbls_lane_steer_monitor (.i_clk, .i_rst,
  .i_paired_lane_mode, .i_dual_data, .i_prog_req, .i_data_req, .o_data_memory_bus,
  .o_data_store, .o_prog_impl_wr, .o_data_expl_wr, .o_data_impl_wr, .o_reject);

// [dv/tb.sv]
// Purpose: self-checking bench for the lane steering block
// Assumes: one clock of latency, inputs driven on the falling edge
// Notes:   rows come from two memory models
`timescale 1ns/1ps
module tb;
  import dbls_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pl = 1'b0, dd = 1'b0, short_sign_extend_bit = 1'b0;
  dbls_req_t pq = '0, dq = '0;
  logic [3:0] pa = 4'h0, da = 4'h0;
  logic [63:0] pr, pn, dr, dn, pb, db;
  logic ps, ds, rej;
  dbls_wr_t pe, pi, de, di;
  int fails = 0, compares = 0;
  always #25 clk = ~clk;
  dbls_mem_model i_dbls_mem_model_p (.i_row(pa), .o_row(pr), .o_next_row(pn));
  dbls_mem_model i_dbls_mem_model_d (.i_row(da), .o_row(dr), .o_next_row(dn));
  dbls_lane_steer i_dbls_lane_steer (.i_clk(clk), .i_rst(rst), .i_paired_lane_mode(pl),
    .i_dual_data(dd), .i_short_sign_extend_bit(short_sign_extend_bit), .i_prog_req(pq), .i_data_req(dq),
    .i_prog_row(pr), .i_prog_next_row(pn), .i_data_row(dr), .i_data_next_row(dn),
    .o_program_memory_bus(pb), .o_data_memory_bus(db), .o_prog_store(ps),
    .o_data_store(ds), .o_prog_expl_wr(pe), .o_prog_impl_wr(pi), .o_data_expl_wr(de),
    .o_data_impl_wr(di), .o_reject(rej));
  ////////////////////////////////////////////////////////////////////////////
  function automatic dbls_req_t rq(logic st, w, logic [1:0] a, logic el, dir);
    return '{valid: 1'b1, store: st, width: w, addr_lo: a, direct: dir, element: el,
             reg_idx: {3'h4, el}, wdata_expl: 40'hA5C3_9E71_2B, wdata_impl: 40'h5A3C_61E8_D4};
  endfunction
  function automatic logic [63:0] img(logic [63:0] r, n, logic w, logic [1:0] a);
    logic [15:0] e, i;
    logic [31:0] x, y;
    e = r[a*16 +: 16];
    i = a[1] ? n[a[0]*16 +: 16] : r[(a+2)*16 +: 16];
    x = a[0] ? r[63:32] : r[31:0];
    y = a[0] ? n[31:0] : r[63:32];
    if (w) return {pl ? y : 32'h0, x};
    return {16'h0, pl ? i : 16'h0, 16'h0, e};
  endfunction
  function automatic logic [63:0] sti(dbls_req_t q);
    if (q.width) return {pl ? q.wdata_impl[39:8] : 32'h0, q.wdata_expl[39:8]};
    return {16'h0, pl ? q.wdata_impl[23:8] : 16'h0, 16'h0, q.wdata_expl[23:8]};
  endfunction
  function automatic logic [39:0] ld(logic [31:0] v, logic w);
    if (w) return {v, 8'h00};
    return {(short_sign_extend_bit && v[15]) ? 16'hFFFF : 16'h0000, v[15:0], 8'h00};
  endfunction
  task automatic chk(logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic vb(dbls_req_t q, logic [63:0] r, n, b, dbls_wr_t e, i, logic st);
    logic [63:0] x;
    logic [44:0] xe, xi;
    if (q.valid !== 1'b1) begin
      chk(b, '0);
      chk({st, e.valid, i.valid}, '0);
      return;
    end
    x = q.store ? sti(q) : img(r, n, q.width, q.addr_lo);
    chk(b, x);
    chk({st, e.valid, i.valid}, {q.store, !q.store, pl && !q.store});
    xe = {q.element, q.reg_idx, ld(x[31:0], q.width)};
    xi = {~q.element, q.reg_idx, ld(x[63:32], q.width)};
    if (!q.store) chk({e.element, e.reg_idx, e.data}, xe);
    if (i.valid === 1'b1) chk({i.element, i.reg_idx, i.data}, xi);
  endtask
  task automatic step(dbls_req_t p, d);
    pq = p;
    dq = d;
    @(negedge clk);
    chk(rej, 1'b0);
    vb(p, pr, pn, pb, pe, pi, ps);
    vb(d, dr, dn, db, de, di, ds);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_short();
    dbls_req_t p, d;
    dd = 1'b1;
    for (int m = 0; m < 2; m++) begin
      for (int a = 0; a < 4; a++) begin
        pl = m[0];
        short_sign_extend_bit = a[1] ^ m[0];
        pa = 4'(a + 6);
        da = 4'(a * 5);
        p = rq(1'b0, 1'b0, 2'(a), a[0], 1'b0);
        d = rq(1'b0, 1'b0, 2'(3 - a), ~a[0], 1'b0);
        step(p, d);
      end
    end
  endtask
  task automatic t_norm();
    dd = 1'b0;
    for (int k = 0; k < 8; k++) begin
      pl = k[2];
      da = 4'(k * 3);
      step('0, rq(1'b0, 1'b1, {1'b0, k[0]}, k[1], k[1]));
    end
  endtask
  task automatic t_mixed();
    dd = 1'b1;
    for (int m = 0; m < 2; m++) begin
      pl = m[0];
      step(rq(1'b0, 1'b0, 2'h2, 1'b0, 1'b0), rq(1'b0, 1'b1, 2'h1, 1'b1, 1'b0));
      step(rq(1'b0, 1'b1, 2'h1, 1'b1, 1'b0), rq(1'b0, 1'b0, 2'h3, 1'b0, 1'b0));
      step(rq(1'b1, m[0], 2'h0, 1'b0, 1'b0), rq(1'b1, ~m[0], 2'h1, 1'b1, 1'b0));
    end
  endtask
  task automatic t_reject();
    dd = 1'b1;
    pl = 1'b1;
    for (int k = 0; k < 2; k++) begin
      pq = rq(1'b0, 1'b1, 2'h0, 1'b0, k[0]);
      dq = rq(1'b0, 1'b0, 2'h2, 1'b1, ~k[0]);
      @(negedge clk);
      chk({rej, ps, ds, pe.valid, de.valid, pi.valid, di.valid}, 7'h40);
      chk(pb | db, '0);
    end
    step('0, '0);
  endtask
  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(db | pb, '0);
    t_short();
    t_norm();
    t_mixed();
    t_reject();
    complete_run();
  end
  initial begin
    #(3000 * 50);
    fails++;
    complete_run();
  end
endmodule
